// ---- hdl/clkgen_pkg.sv ----
// constants for the clock generator control and status block
package clkgen_pkg;
	// register offsets
	localparam logic [3:0] POST_DIVIDER_OFS     = 4'h2;
	localparam logic [3:0] CLOCK_FLAGS_OFS      = 4'h3;
	localparam logic [3:0] CLOCK_IRQ_ENABLE_OFS = 4'h4;
	localparam logic [3:0] CLOCK_SELECT_OFS     = 4'h5;
	// flags register fields
	localparam int TICK_BIT   = 7;
	localparam int POR_BIT    = 6;
	localparam int LVR_BIT    = 5;
	localparam int LCHG_BIT   = 4;
	localparam int LOCK_BIT   = 3;
	localparam int BADA_BIT   = 2;
	localparam int SCHG_BIT   = 1;
	localparam int SCM_BIT    = 0;
	// clock select fields
	localparam int SEL_BIT    = 7;
	localparam int PSEUDO_STOP_SELECT_BIT   = 6;
	localparam int XCFG_BIT   = 5;
	localparam int SWAI_BIT   = 3;
	localparam int TWAI_BIT   = 1;
	localparam int WWAI_BIT   = 0;
	// post divider width and reset value, interrupt enable and write-one-clear masks
	localparam int PDIV_W     = 5;
	localparam logic [4:0] PDIV_RESET = 5'h00;
	localparam logic [7:0] IRQ_EN_MASK = 8'h92;
	localparam logic [7:0] FLAG_W1C_MASK = 8'hF6;
	// bus clock divides its source by this
	localparam int BUS_DIV    = 2;
endpackage

// ---- hdl/clk_divider.sv ----
// programmable clock divider used for the post and bus dividers
`timescale 1ns/10ps
module clk_divider #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] half_count,
	output logic              clk_out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         out;
	} div_state_t;
	div_state_t st_reg;
	div_state_t st_next;

	// toggle output every half_count edges: divide by 2*half_count
	always_comb
	begin
		st_next = st_reg;
		if (st_reg.cnt >= half_count - W'(1))
		begin
			st_next.cnt = '0;
			st_next.out = ~st_reg.out;
		end
		else
			st_next.cnt = st_reg.cnt + W'(1);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	// zero passes the clock undivided
	assign clk_out = (half_count == '0) ? clk : st_reg.out;
endmodule // clk_divider

// ---- hdl/clock_gen_status_select.sv ----
// control and status registers of the clock and reset generator
//
// Added by the designer: strobed register access.
`timescale 1ns/10ps
module clock_gen_status_select (
	input  wire logic       SYS_CLK,
	input  wire logic       NRST,
	input  wire logic [3:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       LOOP_OSC_CLOCK,
	input  wire logic       CRYSTAL_CLOCK,
	input  wire logic       LOCK_DETECT,
	input  wire logic       SELF_CLOCK_ACTIVE,
	input  wire logic       TICK_PERIOD_END,
	input  wire logic       POWER_ON_EVENT,
	input  wire logic       LOW_VOLTAGE_EVENT,
	input  wire logic       BAD_ADDRESS_EVENT,
	input  wire logic       WAIT_ENTRY,
	input  wire logic       STOP_ENTRY,
	input  wire logic       STOP_ACTIVE,
	input  wire logic       WAIT_ACTIVE,
	input  wire logic       SPECIAL_MODE,
	input  wire logic       OSC_CONFIG_FULL_SWING,
	input  wire logic       SYNTH_POWER_ON,
	output logic            SYNTHESIZED_CLOCK,
	output logic            BUS_CLOCK,
	output logic            SYNTH_POWER_DOWN,
	output logic            OSC_ENABLE,
	output logic            TICK_RUN,
	output logic            TICK_INIT,
	output logic            WATCHDOG_RUN,
	output logic            WATCHDOG_INIT,
	output logic            IRQ
);
	typedef struct packed {
		logic [4:0] pdiv;
		logic       tick_f;
		logic       por_f;
		logic       lvr_f;
		logic       lchg_f;
		logic       bada_f;
		logic       schg_f;
		logic       lock_q;
		logic       scm_q;
		logic       tick_ie;
		logic       lchg_ie;
		logic       schg_ie;
		logic       sel;
		logic       pseudo_stop_select;
		logic       swai;
		logic       twai;
		logic       wwai;
		logic       wwai_done;
		logic       xcfg;
		logic       tick_init;
		logic       wdog_init;
		logic [7:0] rdata;
	} ctl_state_t;
	ctl_state_t st_reg;
	ctl_state_t st_next;

	logic       lock_now;
	logic [7:0] flags_view;
	logic [7:0] sel_view;
	logic [7:0] ie_view;
	logic [7:0] clr;
	logic       wr_flags;
	logic       wr_sel;
	logic       bus_src;
	logic [4:0] bus_half;

	// status seen by software
	assign lock_now = LOCK_DETECT & ~SELF_CLOCK_ACTIVE;
	assign flags_view = {st_reg.tick_f, st_reg.por_f, st_reg.lvr_f,
		st_reg.lchg_f, st_reg.lock_q, st_reg.bada_f,
		st_reg.schg_f, st_reg.scm_q};
	assign ie_view = {st_reg.tick_ie, 2'b00, st_reg.lchg_ie, 2'b00,
		st_reg.schg_ie, 1'b0};
	assign sel_view = {st_reg.sel, st_reg.pseudo_stop_select, st_reg.xcfg, 1'b0,
		st_reg.swai, 1'b0, st_reg.twai, st_reg.wwai};
	assign wr_flags = WR && (ADDR == clkgen_pkg::CLOCK_FLAGS_OFS);
	assign wr_sel = WR && (ADDR == clkgen_pkg::CLOCK_SELECT_OFS);
	assign clr = wr_flags ? (WDATA & clkgen_pkg::FLAG_W1C_MASK) : 8'h00;

	// register updates; hardware sets are applied after clears
	always_comb
	begin
		st_next = st_reg;
		st_next.lock_q = lock_now;
		st_next.scm_q = SELF_CLOCK_ACTIVE;
		st_next.xcfg = OSC_CONFIG_FULL_SWING;
		st_next.tick_init = WAIT_ENTRY & st_reg.twai;
		st_next.wdog_init = WAIT_ENTRY & st_reg.wwai;
		// post divider write guard
		if (WR && ADDR == clkgen_pkg::POST_DIVIDER_OFS && !st_reg.sel)
			st_next.pdiv = WDATA[clkgen_pkg::PDIV_W-1:0];
		// write-one clears
		if (clr[clkgen_pkg::TICK_BIT])
			st_next.tick_f = 1'b0;
		if (clr[clkgen_pkg::POR_BIT])
			st_next.por_f = 1'b0;
		if (clr[clkgen_pkg::LVR_BIT])
			st_next.lvr_f = 1'b0;
		if (clr[clkgen_pkg::LCHG_BIT])
			st_next.lchg_f = 1'b0;
		if (clr[clkgen_pkg::BADA_BIT])
			st_next.bada_f = 1'b0;
		if (clr[clkgen_pkg::SCHG_BIT])
			st_next.schg_f = 1'b0;
		// hardware sets win over write-one clears; power-on or low-voltage clears the bad-address flag over its set
		if (TICK_PERIOD_END)
			st_next.tick_f = 1'b1;
		if (POWER_ON_EVENT)
			st_next.por_f = 1'b1;
		if (LOW_VOLTAGE_EVENT)
			st_next.lvr_f = 1'b1;
		if (POWER_ON_EVENT || LOW_VOLTAGE_EVENT)
			st_next.bada_f = 1'b0;
		else if (BAD_ADDRESS_EVENT)
			st_next.bada_f = 1'b1;
		if (lock_now != st_reg.lock_q)
			st_next.lchg_f = 1'b1;
		if (SELF_CLOCK_ACTIVE != st_reg.scm_q)
			st_next.schg_f = 1'b1;
		// interrupt enables
		if (WR && ADDR == clkgen_pkg::CLOCK_IRQ_ENABLE_OFS)
		begin
			st_next.tick_ie = WDATA[clkgen_pkg::TICK_BIT];
			st_next.lchg_ie = WDATA[clkgen_pkg::LCHG_BIT];
			st_next.schg_ie = WDATA[clkgen_pkg::SCHG_BIT];
		end
		// clock select register
		if (wr_sel)
		begin
			if (!WDATA[clkgen_pkg::SEL_BIT] || lock_now)
				st_next.sel = WDATA[clkgen_pkg::SEL_BIT];
			st_next.pseudo_stop_select = WDATA[clkgen_pkg::PSEUDO_STOP_SELECT_BIT];
			st_next.swai = WDATA[clkgen_pkg::SWAI_BIT];
			st_next.twai = WDATA[clkgen_pkg::TWAI_BIT];
			if (SPECIAL_MODE || !st_reg.wwai_done)
			begin
				st_next.wwai = WDATA[clkgen_pkg::WWAI_BIT];
				st_next.wwai_done = 1'b1;
			end
		end
		// forced deselect of the synthesized clock
		if (SELF_CLOCK_ACTIVE || STOP_ENTRY ||
			(WAIT_ENTRY && st_reg.swai))
			st_next.sel = 1'b0;
		// read data held one cycle after the strobe
		st_next.rdata = 8'h00;
		if (RD)
		begin
			unique case (ADDR)
				clkgen_pkg::POST_DIVIDER_OFS:
					st_next.rdata = {3'b000, st_reg.pdiv};
				clkgen_pkg::CLOCK_FLAGS_OFS:
					st_next.rdata = flags_view;
				clkgen_pkg::CLOCK_IRQ_ENABLE_OFS:
					st_next.rdata = ie_view;
				clkgen_pkg::CLOCK_SELECT_OFS:
					st_next.rdata = sel_view;
				default:
					st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			st_reg <= '0;
			st_reg.pdiv <= clkgen_pkg::PDIV_RESET;
			st_reg.por_f <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	// post divider on the loop clock
	clk_divider #(
		.W (clkgen_pkg::PDIV_W)
	) u_post_div (
		.clk        (LOOP_OSC_CLOCK),
		.rst_n      (NRST),
		.half_count (st_reg.pdiv),
		.clk_out    (SYNTHESIZED_CLOCK)
	);

	// bus clock: selected source halved
	assign bus_src = st_reg.sel ? SYNTHESIZED_CLOCK : CRYSTAL_CLOCK;
	assign bus_half = 5'(clkgen_pkg::BUS_DIV / 2);

	clk_divider #(
		.W (5)
	) u_bus_div (
		.clk        (bus_src),
		.rst_n      (NRST),
		.half_count (bus_half),
		.clk_out    (BUS_CLOCK)
	);

	// low-power effects
	assign SYNTH_POWER_DOWN = ~SYNTH_POWER_ON |
		(WAIT_ACTIVE & st_reg.swai & ~SELF_CLOCK_ACTIVE);
	assign OSC_ENABLE = ~STOP_ACTIVE | st_reg.pseudo_stop_select;
	assign TICK_RUN = ~(WAIT_ACTIVE & st_reg.twai) &
		~(STOP_ACTIVE & ~st_reg.pseudo_stop_select);
	assign TICK_INIT = st_reg.tick_init;
	assign WATCHDOG_RUN = ~(WAIT_ACTIVE & st_reg.wwai) &
		~(STOP_ACTIVE & ~st_reg.pseudo_stop_select);
	assign WATCHDOG_INIT = st_reg.wdog_init;
	assign IRQ = (st_reg.tick_f & st_reg.tick_ie) |
		(st_reg.lchg_f & st_reg.lchg_ie) |
		(st_reg.schg_f & st_reg.schg_ie);
	assign RDATA = st_reg.rdata;
endmodule // clock_gen_status_select

// ---- sim/clock_gen_status_select_properties.sv ----
// port assertions for the clock generator control block
`timescale 1ns/10ps
module clock_gen_status_select_check (
	input wire logic       SYS_CLK,
	input wire logic       NRST,
	input wire logic [3:0] ADDR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       LOCK_DETECT,
	input wire logic       SELF_CLOCK_ACTIVE,
	input wire logic       WAIT_ENTRY,
	input wire logic       WAIT_ACTIVE,
	input wire logic       STOP_ACTIVE,
	input wire logic       SYNTH_POWER_ON,
	input wire logic       SYNTH_POWER_DOWN,
	input wire logic       OSC_ENABLE,
	input wire logic       TICK_RUN,
	input wire logic       TICK_INIT,
	input wire logic       WATCHDOG_INIT
);
	logic lock_eff;
	logic flag_rd;
	// lock as software sees it, masked in self-clock
	assign lock_eff = LOCK_DETECT & ~SELF_CLOCK_ACTIVE;
	assign flag_rd = RD && ADDR == clkgen_pkg::CLOCK_FLAGS_OFS;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!NRST);
	a_read_idle: assert property (!RD |=> RDATA == 8'h00)
		else $error("read data not idle");
	a_lock_status: assert property (flag_rd |=>
		RDATA[clkgen_pkg::LOCK_BIT] == $past(lock_eff, 2))
		else $error("lock status wrong");
	a_self_status: assert property (flag_rd |=>
		RDATA[clkgen_pkg::SCM_BIT] == $past(SELF_CLOCK_ACTIVE, 2))
		else $error("self-clock status wrong");
	a_tick_init: assert property (TICK_INIT |-> $past(WAIT_ENTRY))
		else $error("tick init without wait entry");
	a_init_pulse: assert property (TICK_INIT |=> !TICK_INIT)
		else $error("tick init too long");
	a_wdog_init: assert property (WATCHDOG_INIT |-> $past(WAIT_ENTRY))
		else $error("watchdog init without wait entry");
	a_synth_down: assert property (SYNTH_POWER_DOWN && SYNTH_POWER_ON |-> WAIT_ACTIVE)
		else $error("synthesizer down outside wait");
	a_osc_stop: assert property (!OSC_ENABLE |-> STOP_ACTIVE)
		else $error("oscillator off outside stop");
	a_tick_run: assert property (!TICK_RUN |-> WAIT_ACTIVE || STOP_ACTIVE)
		else $error("tick halted while running");
endmodule // clock_gen_status_select_check

bind clock_gen_status_select clock_gen_status_select_check chk_u (
	.SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
	.LOCK_DETECT(LOCK_DETECT), .SELF_CLOCK_ACTIVE(SELF_CLOCK_ACTIVE),
	.WAIT_ENTRY(WAIT_ENTRY), .WAIT_ACTIVE(WAIT_ACTIVE),
	.STOP_ACTIVE(STOP_ACTIVE), .SYNTH_POWER_ON(SYNTH_POWER_ON),
	.SYNTH_POWER_DOWN(SYNTH_POWER_DOWN),
	.OSC_ENABLE(OSC_ENABLE), .TICK_RUN(TICK_RUN), .TICK_INIT(TICK_INIT),
	.WATCHDOG_INIT(WATCHDOG_INIT));

// ---- sim/test_clock_gen_status_select.sv ----
// self-checking bench for the clock generator control block
`timescale 1ns/10ps
module test_clock_gen_status_select;
	logic       sys_clk = 0, loop_clk = 0, xtal_clk = 0, nrst = 0;
	logic [3:0] addr = 0;
	logic [7:0] wdata = 0, rdata, d;
	logic       wr_s = 0, rd_s = 0, rd_d = 0, lock = 0, self_c = 0;
	logic       wait_act = 0, irq, stop_act = 0, spec = 0;
	logic       pdn, osc_en, t_run, w_run;
	logic [5:0] ev = 0;
	logic [7:0] exp_q[$];
	logic [7:0] ev_exp[4] = '{8'h80, 8'h40, 8'h20, 8'h04};
	int         error_cnt = 0, cmp_count = 0, seed = 27786;
	// register clock and two unrelated source clocks
	always #12.5 sys_clk = ~sys_clk;
	always #7 loop_clk = ~loop_clk;
	always #11 xtal_clk = ~xtal_clk;
	clock_gen_status_select dut_u (
		.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
		.WR(wr_s), .RD(rd_s), .RDATA(rdata), .LOOP_OSC_CLOCK(loop_clk),
		.CRYSTAL_CLOCK(xtal_clk), .LOCK_DETECT(lock),
		.SELF_CLOCK_ACTIVE(self_c), .TICK_PERIOD_END(ev[0]),
		.POWER_ON_EVENT(ev[1]), .LOW_VOLTAGE_EVENT(ev[2]),
		.BAD_ADDRESS_EVENT(ev[3]), .WAIT_ENTRY(ev[4]), .STOP_ENTRY(ev[5]),
		.STOP_ACTIVE(stop_act), .WAIT_ACTIVE(wait_act), .SPECIAL_MODE(spec),
		.OSC_CONFIG_FULL_SWING(1'b1), .SYNTH_POWER_ON(1'b1),
		.SYNTHESIZED_CLOCK(), .BUS_CLOCK(), .SYNTH_POWER_DOWN(pdn),
		.OSC_ENABLE(osc_en), .TICK_RUN(t_run), .TICK_INIT(),
		.WATCHDOG_RUN(w_run),
		.WATCHDOG_INIT(), .IRQ(irq));
	task check(input logic [7:0] seen, input logic [7:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask
	// write, optionally with event pulses in the same cycle
	task wr(input logic [3:0] a, input logic [7:0] v, input logic [5:0] e);
		addr <= a;
		wdata <= v;
		wr_s <= 1;
		ev <= e;
		@(posedge sys_clk);
		wr_s <= 0;
		ev <= 0;
		@(posedge sys_clk);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		addr <= a;
		rd_s <= 1;
		@(posedge sys_clk);
		rd_s <= 0;
		@(posedge sys_clk);
	endtask
	task irq_is(input logic v);
		#1 check({7'h00, irq}, {7'h00, v});
	endtask
	task complete_run;
		$display("mismatches %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// read data monitor against oldest expectation
	always @(posedge sys_clk)
		rd_d <= rd_s;
	always @(negedge sys_clk)
		if (rd_d)
			check(rdata, exp_q.pop_front());
	// watchdog against a hung run
	initial
	begin
		repeat (3000) @(posedge sys_clk);
		error_cnt++;
		complete_run;
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1;
		rd(3, 8'h40);
		rd(2, 8'h00);
		rd(4, 8'h00);
		rd(5, 8'h20);
		wr(3, 8'h00, 0);
		rd(3, 8'h40);
		wr(3, 8'h40, 0);
		rd(3, 8'h00);
		// each sticky event sets, survives zero, clears on one
		for (int i = 0; i < 4; i++)
		begin
			wr(4'hF, 8'h00, 6'(1 << i));
			wr(3, 8'h00, 0);
			rd(3, ev_exp[i]);
			wr(3, ev_exp[i], 0);
			rd(3, 8'h00);
		end
		wr(4'hF, 8'h00, 6'h08);
		wr(4'hF, 8'h00, 6'h04);
		rd(3, 8'h20);
		wr(3, 8'h20, 0);
		wr(3, 8'h80, 6'h01);
		rd(3, 8'h80);
		wr(4, 8'h80, 0);
		irq_is(1);
		wr(4, 8'h00, 0);
		irq_is(0);
		wr(3, 8'h80, 0);
		wr(5, 8'h81, 0);
		rd(5, 8'h21);
		lock <= 1;
		wr(4'hF, 8'h00, 0);
		rd(3, 8'h18);
		wr(3, 8'h10, 0);
		rd(3, 8'h08);
		wr(5, 8'h80, 0);
		rd(5, 8'hA1);
		wr(5, 8'h8A, 0);
		rd(5, 8'hAB);
		wr(2, 8'h05, 0);
		rd(2, 8'h00);
		wait_act <= 1;
		wr(4'hF, 8'h00, 6'h10);
		rd(5, 8'h2B);
		#1 check({4'h0, pdn, t_run, w_run, osc_en}, 8'h09);
		wait_act <= 0;
		wr(5, 8'h80, 0);
		stop_act <= 1;
		wr(4'hF, 8'h00, 6'h20);
		#1 check({4'h0, pdn, t_run, w_run, osc_en}, 8'h00);
		stop_act <= 0;
		rd(5, 8'h21);
		wr(5, 8'h80, 0);
		self_c <= 1;
		wr(4'hF, 8'h00, 0);
		rd(3, 8'h13);
		rd(5, 8'h21);
		wr(4, 8'h12, 0);
		irq_is(1);
		wr(3, 8'h12, 0);
		irq_is(0);
		self_c <= 0;
		// random post divider values while unselected
		for (int i = 0; i < 8; i++)
		begin
			d = 8'($random(seed));
			wr(2, d, 0);
			rd(2, d & 8'h1F);
		end
		// special mode lets the watchdog-wait bit change again
		spec <= 1;
		wr(5, 8'h00, 0);
		rd(5, 8'h20);
		complete_run;
	end
endmodule // test_clock_gen_status_select
